// ### rtl/psw_pkg.sv
// package: register map, field layout, timing constants and carrier types
// Behaviour
// - per-source enable, status output of pending enabled
// - twelve named power-domain interrupt sources
// - each source maskable and clearable by software
// - first power-on, power-off irq, shutdown power-on
// - first battery power-on yields ok, reset flag, first power-on pulse
// - charger irq on insert, remove, full, low
// - pin monitor irq only for pmu-owned pins
// - timer reaching duration asserts sleep end
// - oscillator and analog up before timeout sleep end
// - preparation end stops timer, resumes baseband clock
// - async wake starts analog power-up at once
// - async wake extends count, then sleep end
// - sleep powers off digital, keeps retention, clock
// - converter, oscillator, regulator steps have programmable timing
// - shutdown wakes only on power-key pin
// - sleep clock is 62.5 kHz, needs calibration
package psw_pkg;
  localparam int NSRC = 12;
  // source bit positions
  localparam int SRC_CAL = 0;
  localparam int SRC_WAKE = 1;
  localparam int SRC_ALMA = 2;
  localparam int SRC_ALMB = 3;
  localparam int SRC_KEY = 4;
  localparam int SRC_PKEY = 5;
  localparam int SRC_WDT = 6;
  localparam int SRC_CHG = 7;
  localparam int SRC_ULV = 8;
  localparam int SRC_PIN = 9;
  localparam int SRC_QUADRATURE_DECODER_IRQ = 10;
  localparam int SRC_OTP = 11;
  // register offsets (byte addresses)
  localparam logic [7:0] A_IRQ_EN = 8'h00;
  localparam logic [7:0] A_IRQ_PEND = 8'h04;
  localparam logic [7:0] A_IRQ_CLR = 8'h08;
  localparam logic [7:0] A_SLP_DUR = 8'h0C;
  localparam logic [7:0] A_SLP_CTRL = 8'h10;
  localparam logic [7:0] A_SLP_CNT = 8'h14;
  localparam logic [7:0] A_T_OSC = 8'h18;
  localparam logic [7:0] A_T_EXT = 8'h1C;
  localparam logic [7:0] A_T_SEQ = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_PIN_OWN = 8'h28;
  // control bits in sleep control register
  localparam int CTL_START = 0;
  localparam int CTL_SHUT = 1;
  localparam int CTL_CAL = 2;
  // reset values
  localparam logic [11:0] RST_EN = 12'h000;
  localparam logic [7:0] RST_T_OSC = 8'h04;
  localparam logic [7:0] RST_T_EXT = 8'h04;
  localparam logic [7:0] RST_T_SEQ = 8'h02;
  // low-power clock rate and the divider count from the system clock
  localparam int CLK_HZ = 250_000_000;
  localparam int LP_HZ_X10 = 625_000; // 62.5 kHz times ten
  localparam int LP_DIV = (CLK_HZ / LP_HZ_X10) * 10;
  typedef enum logic [2:0] {
    PSW_RUN = 3'b000,
    PSW_SLEEP = 3'b001,
    PSW_DCDC = 3'b010,
    PSW_OSC = 3'b011,
    PSW_LDO = 3'b100,
    PSW_PREP = 3'b101,
    PSW_SHUT = 3'b110
  } psw_state_t;
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } psw_bus_t;
  // power enable outputs
  typedef struct packed {
    logic dcdc;
    logic osc;
    logic ldo;
    logic pd_on;
    logic bb_clk;
  } psw_pwr_t;
endpackage

// ### rtl/psw_sync.sv
// two-stage synchroniser with rising-edge pulse on the settled value
`timescale 1ns/10ps
module psw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // asynchronous levels in, settled levels and rising pulses out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } psw_sync_t;
  psw_sync_t q, next_q;
  // first stage feeds only the second
  always_comb begin
    next_q.s1 = i_async;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign o_level = q.s2;
  assign o_rise = q.s2 & ~q.s3;
endmodule

// ### rtl/psw_pmu.sv
// power management interrupt controller and sleep timer sequencer
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module psw_pmu
  import psw_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int NPIN = 8,
  parameter int LP_DIVIDE = LP_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire psw_bus_t i_bus,
  output logic [31:0] o_rdata,
  // asynchronous event sources (levels from other domains)
  input wire logic i_cal_done,
  input wire logic i_alarm_a_irq,
  input wire logic i_alarm_b_irq,
  input wire logic i_key_event,
  input wire logic i_power_key,
  input wire logic i_watchdog_irq,
  input wire logic [3:0] i_charger_evt,
  input wire logic i_ulv_off,
  input wire logic [NPIN-1:0] i_pin_mon,
  input wire logic i_quadrature_decoder_irq,
  input wire logic i_over_temp,
  input wire logic i_wake_req,
  input wire logic i_vbat_present,
  // interrupt and power-on indications
  output logic o_irq_status,
  output logic o_first_power_on,
  output logic o_power_off_irq,
  output logic o_shutdown_power_on,
  output logic o_battery_ok,
  output logic o_battery_on_reset_flag,
  output logic o_power_key,
  // sleep sequencing
  output logic o_sleep_end,
  output logic o_sleep_timer_wake_irq,
  output logic o_oscillator_enable_out,
  output psw_pwr_t o_pwr,
  output logic o_retain
);
  // six single events, four charger bits, ulv, the pins, then quadrature_decoder_irq,
  // over-temperature, wake request and battery presence
  localparam int NA = 11 + NPIN + 4;
  localparam int DW = $clog2(LP_DIVIDE);
  localparam logic [DW-1:0] DIV_LAST = DW'(LP_DIVIDE - 1);

  typedef struct packed {
    logic [11:0] en;
    logic [11:0] pend;
    logic [NPIN-1:0] pin_own;
    logic [CNT_W-1:0] dur;
    logic [CNT_W-1:0] cnt;
    logic [7:0] t_osc;
    logic [7:0] t_ext;
    logic [7:0] t_seq;
    logic [7:0] step;
    logic cal_ok;
    logic shut_req;
    logic async_wake;
    logic shut_wake;
    logic [7:0] ext;
    logic [DW-1:0] div;
    psw_state_t st;
    logic vbat_seen;
    logic bor;
    logic first_on;
    logic off_irq;
    logic shut_on;
    logic end_pulse;
    logic [31:0] rdata;
    logic irq;
    psw_pwr_t pwr;
    logic retain;
  } psw_st_t;
  psw_st_t q, next_q;

  logic [NA-1:0] s_lvl, s_rise;
  logic [11:0] evt;
  logic lp_tick;

  // every pin-domain input is settled before any logic looks at it
  psw_sync #(.W(NA)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_cal_done, i_alarm_a_irq, i_alarm_b_irq, i_key_event,
              i_power_key, i_watchdog_irq, i_charger_evt, i_ulv_off,
              i_pin_mon, i_quadrature_decoder_irq, i_over_temp,
              i_wake_req, i_vbat_present}),
    .o_level(s_lvl),
    .o_rise(s_rise)
  );

  // compare two counts; shared by power-up start and duration checks
  function automatic logic reached(input logic [CNT_W-1:0] a,
                                   input logic [CNT_W-1:0] b);
    reached = (a >= b);
  endfunction

  // map settled edges onto source bits
  always_comb begin
    evt = '0;
    evt[SRC_CAL] = s_rise[NA-1];
    evt[SRC_ALMA] = s_rise[NA-2];
    evt[SRC_ALMB] = s_rise[NA-3];
    evt[SRC_KEY] = s_rise[NA-4];
    evt[SRC_PKEY] = s_rise[NA-5];
    evt[SRC_WDT] = s_rise[NA-6];
    evt[SRC_CHG] = |s_rise[NA-7 -: 4];
    evt[SRC_ULV] = s_rise[NA-11];
    evt[SRC_PIN] = |(s_rise[NA-12 -: NPIN] & q.pin_own);
    evt[SRC_QUADRATURE_DECODER_IRQ] = s_rise[3];
    evt[SRC_OTP] = s_rise[2];
    evt[SRC_WAKE] = q.end_pulse;
  end

  // low-power tick: one pulse per 62.5 kHz period
  assign lp_tick = (q.div == DIV_LAST);

  always_comb begin
    next_q = q;
    next_q.end_pulse = 1'b0;
    next_q.first_on = 1'b0;
    next_q.off_irq = 1'b0;
    next_q.shut_on = 1'b0;
    next_q.div = lp_tick ? '0 : q.div + 1'b1;
    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        A_IRQ_EN: next_q.en = i_bus.wdata[11:0];
        A_IRQ_CLR: next_q.pend = q.pend & ~i_bus.wdata[11:0];
        A_SLP_DUR: next_q.dur = i_bus.wdata[CNT_W-1:0];
        A_T_OSC: next_q.t_osc = i_bus.wdata[7:0];
        A_T_EXT: next_q.t_ext = i_bus.wdata[7:0];
        A_T_SEQ: next_q.t_seq = i_bus.wdata[7:0];
        A_PIN_OWN: next_q.pin_own = i_bus.wdata[NPIN-1:0];
        A_SLP_CTRL: begin
          if (i_bus.wdata[CTL_CAL]) begin
            next_q.cal_ok = 1'b1;
          end
          // duration is compared live from its register throughout the sleep, not latched at start
          if (i_bus.wdata[CTL_START] && q.st == PSW_RUN && q.cal_ok) begin
            next_q.st = PSW_SLEEP;
            next_q.cnt = '0;
            next_q.async_wake = 1'b0;
            next_q.pwr.pd_on = 1'b0;
            next_q.pwr.bb_clk = 1'b0;
            next_q.pwr.osc = 1'b0;
            next_q.pwr.ldo = 1'b0;
            next_q.pwr.dcdc = 1'b0;
          end else if (i_bus.wdata[CTL_SHUT] && q.st == PSW_RUN) begin
            next_q.st = PSW_SHUT;
            next_q.off_irq = 1'b1;
            next_q.pwr = '0;
          end
        end
        default: ;
      endcase
    end
    // hardware sets win over software clear
    next_q.pend = next_q.pend | evt;
    // a status read clears the reset flag, but a new first power-on
    // in the same cycle must not be lost, so the set comes after
    if (i_bus.rd && i_bus.addr == A_STATUS) begin
      next_q.bor = 1'b0;
    end
    // battery first power-on
    if (s_lvl[0] && !q.vbat_seen) begin
      next_q.vbat_seen = 1'b1;
      next_q.bor = 1'b1;
      next_q.first_on = 1'b1;
    end else if (!s_lvl[0]) begin
      next_q.vbat_seen = 1'b0;
    end
    // sleep sequencer, counts on low-power ticks
    case (q.st)
      PSW_RUN: ;
      PSW_SLEEP: begin
        if (lp_tick) begin
          next_q.cnt = q.cnt + 1'b1;
        end
        if (s_rise[1]) begin
          next_q.async_wake = 1'b1;
          next_q.ext = '0;
          next_q.st = PSW_DCDC;
          next_q.step = '0;
          next_q.pwr.dcdc = 1'b1;
        end else if (reached(q.cnt + CNT_W'(q.t_osc) + CNT_W'({q.t_seq, 1'b0}),
                             q.dur)) begin
          next_q.st = PSW_DCDC;
          next_q.step = '0;
          next_q.pwr.dcdc = 1'b1;
        end
      end
      PSW_DCDC, PSW_OSC, PSW_LDO: begin
        if (lp_tick) begin
          next_q.cnt = q.cnt + 1'b1;
          next_q.step = q.step + 1'b1;
          if (q.step + 8'h01 >= q.t_seq) begin
            next_q.step = '0;
            if (q.st == PSW_DCDC) begin
              next_q.st = PSW_OSC;
              next_q.pwr.osc = 1'b1;
            end else if (q.st == PSW_OSC) begin
              next_q.st = PSW_LDO;
              next_q.pwr.ldo = 1'b1;
            end else begin
              next_q.st = PSW_PREP;
              next_q.pwr.pd_on = 1'b1;
            end
          end
        end
      end
      PSW_PREP: begin
        if (lp_tick) begin
          next_q.cnt = q.cnt + 1'b1;
          next_q.step = q.step + 1'b1;
        end
        // a power-on from shutdown ends here with no wake event;
        // timeout ends at duration, async wake once the extension,
        // counted from the request itself, has run out
        if (q.shut_wake) begin
          next_q.st = PSW_RUN;
          next_q.shut_wake = 1'b0;
          next_q.pwr.bb_clk = 1'b1;
        end else if ((!q.async_wake && reached(q.cnt, q.dur)) ||
            (q.async_wake && q.ext >= q.t_ext)) begin
          next_q.st = PSW_RUN;
          next_q.pwr.bb_clk = 1'b1;
          next_q.end_pulse = 1'b1;
        end
      end
      PSW_SHUT: begin
        // supplies come up in the same order as after sleep, so the
        // converter is never asked to feed the regulators cold
        if (s_rise[NA-5]) begin
          next_q.st = PSW_DCDC;
          next_q.step = '0;
          next_q.shut_wake = 1'b1;
          next_q.shut_on = 1'b1;
          next_q.pwr.dcdc = 1'b1;
        end
      end
      default: next_q.st = PSW_RUN;
    endcase
    // low-power ticks since the wake request, held at full scale
    if (lp_tick && q.async_wake && q.ext != 8'hFF) begin
      next_q.ext = q.ext + 8'h01;
    end
    // register reads, answer one cycle later
    next_q.rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        A_IRQ_EN: next_q.rdata = {20'h0, q.en};
        A_IRQ_PEND: next_q.rdata = {20'h0, q.pend};
        A_SLP_DUR: next_q.rdata = 32'(q.dur);
        A_SLP_CNT: next_q.rdata = 32'(q.cnt);
        A_T_OSC: next_q.rdata = {24'h0, q.t_osc};
        A_T_EXT: next_q.rdata = {24'h0, q.t_ext};
        A_T_SEQ: next_q.rdata = {24'h0, q.t_seq};
        A_PIN_OWN: next_q.rdata = 32'(q.pin_own);
        A_STATUS: next_q.rdata = {24'h0, q.async_wake, q.bor, q.cal_ok,
                                  q.vbat_seen, 1'b0, q.st};
        default: next_q.rdata = '0;
      endcase
    end
    next_q.irq = |(next_q.pend & next_q.en);
    // retention flag has its own flop so the pin is glitch free
    next_q.retain = ~next_q.pwr.pd_on;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
      q.en <= RST_EN;
      q.t_osc <= RST_T_OSC;
      q.t_ext <= RST_T_EXT;
      q.t_seq <= RST_T_SEQ;
      q.st <= PSW_RUN;
      q.pwr <= '1;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from state flops
  assign o_rdata = q.rdata;
  assign o_irq_status = q.irq;
  assign o_first_power_on = q.first_on;
  assign o_power_off_irq = q.off_irq;
  assign o_shutdown_power_on = q.shut_on;
  assign o_battery_ok = q.vbat_seen;
  assign o_battery_on_reset_flag = q.bor;
  assign o_power_key = q.pwr.pd_on;
  assign o_sleep_end = q.end_pulse;
  assign o_sleep_timer_wake_irq = q.pend[SRC_WAKE];
  assign o_oscillator_enable_out = q.pwr.osc;
  assign o_pwr = q.pwr;
  assign o_retain = q.retain;
endmodule

// ### verification/psw_pmu_props.sv
// checker: timing relations on the pmu ports
`timescale 1ns/10ps
module psw_pmu_props
  import psw_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire psw_bus_t i_bus,
  input wire logic [31:0] o_rdata,
  // indications and power enables
  input wire logic o_first_power_on,
  input wire logic o_battery_on_reset_flag,
  input wire logic o_sleep_end,
  input wire logic o_sleep_timer_wake_irq,
  input wire logic o_oscillator_enable_out,
  input wire psw_pwr_t o_pwr,
  input wire logic o_retain
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  end_pulse_a: assert property (o_sleep_end |=> !o_sleep_end)
    else $error("sleep end longer than one cycle");
  end_irq_a: assert property (o_sleep_end |=> o_sleep_timer_wake_irq)
    else $error("no wake irq after sleep end");
  end_osc_a: assert property (o_sleep_end |->
    o_oscillator_enable_out && o_pwr.ldo && o_pwr.dcdc)
    else $error("sleep end before analog power up");
  end_clk_a: assert property (o_sleep_end |-> ##[0:1] o_pwr.bb_clk)
    else $error("baseband clock not resumed");
  osc_order_a: assert property ($rose(o_pwr.osc) |-> o_pwr.dcdc)
    else $error("oscillator before converter");
  ldo_order_a: assert property ($rose(o_pwr.ldo) |->
    $past(o_pwr.osc))
    else $error("regulator before oscillator");
  retain_on_a: assert property (o_retain == !o_pwr.pd_on)
    else $error("retention not tied to power down");
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  first_bor_a: assert property (o_first_power_on |=>
    o_battery_on_reset_flag)
    else $error("reset flag missing after first power on");
  end_seen_c: cover property (o_sleep_end);
endmodule
bind psw_pmu psw_pmu_props chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_first_power_on(o_first_power_on),
  .o_battery_on_reset_flag(o_battery_on_reset_flag),
  .o_sleep_end(o_sleep_end), .o_sleep_timer_wake_irq(o_sleep_timer_wake_irq),
  .o_oscillator_enable_out(o_oscillator_enable_out), .o_pwr(o_pwr),
  .o_retain(o_retain));

// ### verification/psw_wake_src.sv
// partner: baseband scheduler raising an asynchronous wake request
`timescale 1ns/10ps
module psw_wake_src (
  // clock
  input wire logic i_clk,
  // command from the bench
  input wire logic i_go,
  input wire logic [15:0] i_delay,
  // wake request level, four cycles wide so the synchroniser sees it
  output logic o_wake_req
);
  int n = -4;
  initial o_wake_req = 1'b0;
  // countdown, then a short high level
  always @(posedge i_clk) begin
    if (i_go) n <= i_delay;
    else if (n > -4) n <= n - 1;
    o_wake_req <= (n <= 0) && (n > -4) && !i_go;
  end
endmodule

// ### verification/tb.sv
// testbench: pmu interrupt controller and sleep sequencer
`timescale 1ns/10ps
module tb;
  import psw_pkg::*;
  logic clk = 0, rst = 1, vbat = 0, wgo = 0;
  logic [11:0] src = 0;
  logic [3:0] chg = 0;
  logic [7:0] pin = 0;
  logic [15:0] wdly = 0;
  psw_bus_t bus = '0;
  logic [31:0] rdata, v;
  logic irq, fpo, poff, spo, bok, bor, pk, send, wirq, osc, ret, wreq;
  psw_pwr_t pwr;
  int n_fail = 0, tests_run = 0, n_end = 0, n_fpo = 0, n_poff = 0, n_spo = 0;
  int mdl = 0, d, te, e0;
  always #2 clk = ~clk;
  psw_wake_src wk_u (.i_clk(clk), .i_go(wgo), .i_delay(wdly),
    .o_wake_req(wreq));
  psw_pmu #(.LP_DIVIDE(4)) dut_u (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus),
    .o_rdata(rdata), .i_cal_done(src[0]), .i_alarm_a_irq(src[2]),
    .i_alarm_b_irq(src[3]), .i_key_event(src[4]), .i_power_key(src[5]),
    .i_watchdog_irq(src[6]), .i_charger_evt(chg), .i_ulv_off(src[8]),
    .i_pin_mon(pin), .i_quadrature_decoder_irq(src[10]),
    .i_over_temp(src[11]), .i_wake_req(wreq), .i_vbat_present(vbat),
    .o_irq_status(irq), .o_first_power_on(fpo), .o_power_off_irq(poff),
    .o_shutdown_power_on(spo), .o_battery_ok(bok),
    .o_battery_on_reset_flag(bor), .o_power_key(pk), .o_sleep_end(send),
    .o_sleep_timer_wake_irq(wirq), .o_oscillator_enable_out(osc),
    .o_pwr(pwr), .o_retain(ret));
  // pulse outputs stand one cycle, so count them as they pass
  always @(posedge clk) begin
    n_end += (send === 1'b1);
    n_fpo += (fpo === 1'b1);
    n_poff += (poff === 1'b1);
    n_spo += (spo === 1'b1);
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, dat};
    @(posedge clk) bus <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) bus <= '0;
    #1 q = rdata;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // a rising edge on one source; pin and charger take a chosen bit
  task pulse(input int i, input int b);
    @(posedge clk);
    if (i == 7) chg[b % 4] <= 1'b1;
    else if (i == 9) pin[b] <= 1'b1;
    else src[i] <= 1'b1;
    repeat (3) @(posedge clk);
    src <= '0;
    chg <= '0;
    pin <= '0;
    repeat (4) @(posedge clk);
  endtask
  // duration first, then start; optional wake after wdly cycles
  task sleep(input int dur, input int dl);
    wr(A_SLP_DUR, dur);
    wr(A_SLP_CTRL, 32'h1);
    #1 chk(pwr, 5'h00);
    chk(ret, 1'b1);
    chk({pk, osc}, 2'b00);
    e0 = n_end;
    if (dl > 0) begin
      wdly <= dl;
      wgo <= 1'b1;
      @(posedge clk) wgo <= 1'b0;
    end
    for (int k = 0; k < 8000 && n_end == e0; k++) @(posedge clk);
    settle;
    chk(n_end, e0 + 1);
    chk(pwr, 5'h1F);
    chk({pk, osc}, 2'b11);
    chk(wirq, 1'b1);
    wr(A_IRQ_CLR, 32'h2);
    settle;
    chk(wirq, 1'b0);
  endtask
  task close_out;
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    void'($urandom(32'hF266));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd(A_IRQ_EN, v); chk(v, 32'h0);
    rd(A_T_OSC, v); chk(v, 32'h4);
    rd(A_T_EXT, v); chk(v, 32'h4);
    rd(A_T_SEQ, v); chk(v, 32'h2);
    rd(8'h3C, v); chk(v, 32'h0);
    chk(pwr, 5'h1F);
    // first battery power on
    @(posedge clk) vbat <= 1'b1;
    settle; settle; settle;
    chk(n_fpo, 1);
    chk({bok, bor}, 2'b11);
    rd(A_STATUS, v); chk(v[6], 1'b1);
    settle;
    chk(bor, 1'b0);
    // pin owned by the pmu only on bit 0; others raise nothing
    wr(A_PIN_OWN, 32'h1);
    pulse(9, 1 + $urandom % 7);
    rd(A_IRQ_PEND, v); chk(v, 32'h0);
    for (int i = 0; i < NSRC; i++) begin
      if (i == 1) continue;
      wr(A_IRQ_EN, 32'h1 << i);
      pulse(i, (i == 9) ? 0 : $urandom % 4);
      mdl |= 1 << i;
      rd(A_IRQ_PEND, v); chk(v, mdl);
      chk(irq, 1'b1);
      wr(A_IRQ_CLR, 32'h1 << i);
      mdl &= ~(1 << i);
      settle;
      chk(irq, 1'b0);
    end
    // masked source stays pending but silent
    wr(A_IRQ_EN, 32'h0);
    pulse(2, 0);
    mdl |= 4;
    settle;
    chk(irq, 1'b0);
    rd(A_IRQ_PEND, v); chk(v, mdl);
    wr(A_IRQ_CLR, 32'hFFF);
    // start refused before calibration
    wr(A_SLP_CTRL, 32'h1);
    settle;
    chk(pwr, 5'h1F);
    wr(A_SLP_CTRL, 32'h4);
    // timeout wake: full count kept for compensation
    d = 20 + $urandom % 32;
    sleep(d, 0);
    rd(A_SLP_CNT, v); chk(v, d);
    // asynchronous wake with a new extension
    // extension no shorter than the three power-up steps of 2 ticks
    te = 6 + $urandom % 3;
    wr(A_T_EXT, te);
    rd(A_T_EXT, v); chk(v, te);
    sleep(400, 100);
    rd(A_SLP_CNT, v);
    chk(v >= 25 + te - 1 && v <= 25 + te + 2, 1'b1);
    chk(v < 400, 1'b1);
    rd(A_STATUS, v); chk(v[7], 1'b1);
    // shutdown wakes on the power key only
    wr(A_SLP_CTRL, 32'h2);
    settle;
    chk(n_poff, 1);
    wdly <= 2;
    wgo <= 1'b1;
    @(posedge clk) wgo <= 1'b0;
    repeat (12) @(posedge clk);
    chk(n_spo, 0);
    pulse(5, 0);
    chk(n_spo, 1);
    close_out;
  end
endmodule
